// ### vic_pkg.sv
// vic_pkg: register map, field layout and channel numbers of the vectored interrupt controller
// assumes a 32-bit avalon-mm register bus and one system clock
package vic_pkg;
   localparam int VIC_NUM_CH = 28;
   localparam int VIC_NUM_SLOTS = 16;
   localparam int VIC_SLOT_W = 4;
   // register byte offsets
   localparam logic [7:0] VIC_OFS_IRQ_STATUS = 8'h00;
   localparam logic [7:0] VIC_OFS_FIQ_STATUS = 8'h04;
   localparam logic [7:0] VIC_OFS_RAW = 8'h08;
   localparam logic [7:0] VIC_OFS_SELECT = 8'h0C;
   localparam logic [7:0] VIC_OFS_ENABLE = 8'h10;
   localparam logic [7:0] VIC_OFS_ENABLE_CLR = 8'h14;
   localparam logic [7:0] VIC_OFS_SOFT_SET = 8'h18;
   localparam logic [7:0] VIC_OFS_SOFT_CLR = 8'h1C;
   localparam logic [7:0] VIC_OFS_VECT_ADDR = 8'h30;
   localparam logic [7:0] VIC_OFS_DEF_ADDR = 8'h34;
   localparam logic [7:0] VIC_OFS_EVT_STATUS = 8'h38;
   localparam logic [7:0] VIC_OFS_EVT_MASK = 8'h3C;
   localparam logic [7:0] VIC_OFS_SLOT_ADDR = 8'h40;
   localparam logic [7:0] VIC_OFS_SLOT_CTRL = 8'h80;
   localparam logic [7:0] VIC_OFS_SLOT_END = 8'hC0;
   // slot control word layout
   localparam int VIC_CTRL_EN_BIT = 5;
   localparam int VIC_CTRL_CH_W = 5;
   // sticky event bits
   localparam int VIC_EVT_W = 2;
   localparam int VIC_EVT_FIQ = 0;
   localparam int VIC_EVT_IRQ = 1;
   // channel numbers
   localparam int VIC_CH_WDT = 0;
   localparam int VIC_CH_SOFT = 1;
   localparam int VIC_CH_DBG_RX = 2;
   localparam int VIC_CH_DBG_TX = 3;
   localparam int VIC_CH_TMR0 = 4;
   localparam int VIC_CH_TMR1 = 5;
   localparam int VIC_CH_UART0 = 6;
   localparam int VIC_CH_UART1 = 7;
   localparam int VIC_CH_PWM = 8;
   localparam int VIC_CH_I2C = 9;
   localparam int VIC_CH_SPI0 = 10;
   localparam int VIC_CH_SPI1 = 11;
   localparam int VIC_CH_PLL = 12;
   localparam int VIC_CH_RTC = 13;
   localparam int VIC_CH_EXT0 = 14;
   localparam int VIC_CH_ADC = 18;
   localparam int VIC_CH_CAN_AF = 19;
   localparam int VIC_CH_CAN_TR = 20;
   localparam int VIC_NUM_CAN = 4;
   localparam int VIC_NUM_EXT = 4;
   localparam logic [31:0] VIC_ZERO = 32'h0000_0000;
endpackage : vic_pkg

// ### vic_ctrl.sv
// vic_ctrl: vectored interrupt controller with avalon-mm register slave
// assumes all request inputs are synchronous, level-sensitive, active high
// Behaviour
// - each channel is fast, vectored slot, or non-vectored, set by software
// - class and slot settings can change anytime and apply to next arbitration
// - fast class outranks normal; all fast requests ORed onto fast output
// - fast status word shows enabled requesting channels of the fast class
// - sixteen vectored slots, any channel to any slot, between fast and plain
// - slot 0 highest priority, slot 15 lowest, fixed by index
// - enabled channels without slot or fast class are lowest-priority non-vectored
// - normal output high while any vectored or non-vectored request active
// - vector register gives top active slot address, else the default address
// - normal status register shows active normal channels
// - each peripheral gives one line, the OR of its internal flags, except debug comm and each can controller, which give separate rx and tx lines
// - ch0 watchdog, ch1 software only, ch2/3 debug receive and transmit
// - ch4 and ch5 are timer 0 and 1 match and capture ORs
// - ch6 serial port 0 flags, ch7 serial port 1 plus modem status
// - ch8 pwm, ch9 i2c, ch10 spi0, ch11 spi1 ORed with ssp flags
// - ch12 pll lock, ch13 rtc increment and alarm combined
// - ch14 to ch17 external pin requests 0 to 3
// - ch18 converter, ch19 can filter, ch20-27 can tx/rx pairs 1 to 4
`timescale 1ns/100ps
module vic_ctrl
   import vic_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // avalon-mm slave
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // peripheral request flags
   input wire logic watchdog_timeout_flag_in,
   input wire logic debug_comm_receive_in,
   input wire logic debug_comm_transmit_in,
   input wire logic [7:0] timer0_flags_in,
   input wire logic [7:0] timer1_flags_in,
   input wire logic uart0_rx_line_status_flag_in,
   input wire logic uart0_tx_holding_empty_flag_in,
   input wire logic uart0_rx_data_available_flag_in,
   input wire logic uart0_char_timeout_flag_in,
   input wire logic uart1_rx_line_status_flag_in,
   input wire logic uart1_tx_holding_empty_flag_in,
   input wire logic uart1_rx_data_available_flag_in,
   input wire logic uart1_char_timeout_flag_in,
   input wire logic uart1_modem_status_flag_in,
   input wire logic [6:0] pwm_match_flags_in,
   input wire logic i2c_state_change_flag_in,
   input wire logic spi0_transfer_done_flag_in,
   input wire logic spi0_mode_fault_flag_in,
   input wire logic spi1_transfer_done_flag_in,
   input wire logic spi1_mode_fault_flag_in,
   input wire logic ssp_tx_fifo_flag_in,
   input wire logic ssp_rx_fifo_flag_in,
   input wire logic ssp_rx_timeout_flag_in,
   input wire logic ssp_rx_overrun_flag_in,
   input wire logic pll_locked_flag_in,
   input wire logic rtc_increment_flag_in,
   input wire logic rtc_alarm_flag_in,
   input wire logic [3:0] ext_pin_request_in,
   input wire logic adc_done_flag_in,
   input wire logic can_filter_flag_in,
   input wire logic [3:0] can_tx_flag_in,
   input wire logic [3:0] can_rx_flag_in,
   // processor core
   output logic fast_interrupt_request_out,
   output logic normal_interrupt_request_out,
   output logic event_interrupt_out
);

   // ****************************************
   // request gathering
   // ****************************************
   logic [VIC_NUM_CH-1:0] raw_req;
   logic [VIC_NUM_CH-1:0] soft_req;
   logic [VIC_NUM_CH-1:0] fast_sel;
   logic [VIC_NUM_CH-1:0] enable;
   logic [31:0] slot_addr [VIC_NUM_SLOTS];
   logic [VIC_CTRL_CH_W:0] slot_ctrl [VIC_NUM_SLOTS];
   logic [31:0] default_addr;
   logic [VIC_EVT_W-1:0] evt_status;
   logic [VIC_EVT_W-1:0] evt_mask;
   logic fast_q;
   logic normal_q;

   always_comb begin
      raw_req = '0;
      raw_req[VIC_CH_WDT] = watchdog_timeout_flag_in;
      raw_req[VIC_CH_DBG_RX] = debug_comm_receive_in;
      raw_req[VIC_CH_DBG_TX] = debug_comm_transmit_in;
      raw_req[VIC_CH_TMR0] = |timer0_flags_in;
      raw_req[VIC_CH_TMR1] = |timer1_flags_in;
      raw_req[VIC_CH_UART0] = uart0_rx_line_status_flag_in | uart0_tx_holding_empty_flag_in
         | uart0_rx_data_available_flag_in | uart0_char_timeout_flag_in;
      raw_req[VIC_CH_UART1] = uart1_rx_line_status_flag_in | uart1_tx_holding_empty_flag_in
         | uart1_rx_data_available_flag_in | uart1_char_timeout_flag_in
         | uart1_modem_status_flag_in;
      raw_req[VIC_CH_PWM] = |pwm_match_flags_in;
      raw_req[VIC_CH_I2C] = i2c_state_change_flag_in;
      raw_req[VIC_CH_SPI0] = spi0_transfer_done_flag_in | spi0_mode_fault_flag_in;
      raw_req[VIC_CH_SPI1] = spi1_transfer_done_flag_in | spi1_mode_fault_flag_in
         | ssp_tx_fifo_flag_in | ssp_rx_fifo_flag_in | ssp_rx_timeout_flag_in
         | ssp_rx_overrun_flag_in;
      raw_req[VIC_CH_PLL] = pll_locked_flag_in;
      raw_req[VIC_CH_RTC] = rtc_increment_flag_in | rtc_alarm_flag_in;
      raw_req[VIC_CH_ADC] = adc_done_flag_in;
      raw_req[VIC_CH_CAN_AF] = can_filter_flag_in;
      for (int i = 0; i < VIC_NUM_EXT; i++) begin
         raw_req[VIC_CH_EXT0 + i] = ext_pin_request_in[i];
      end
      for (int i = 0; i < VIC_NUM_CAN; i++) begin
         raw_req[VIC_CH_CAN_TR + 2 * i] = can_tx_flag_in[i];
         raw_req[VIC_CH_CAN_TR + 2 * i + 1] = can_rx_flag_in[i];
      end
      // channel 1 has no hardware line; only software raises it
      raw_req = raw_req | soft_req;
   end

   // ****************************************
   // classification and arbitration
   // ****************************************
   logic [VIC_NUM_CH-1:0] active_req;
   logic [VIC_NUM_CH-1:0] fast_status;
   logic [VIC_NUM_CH-1:0] irq_status;
   logic [VIC_NUM_SLOTS-1:0] slot_hit;
   logic [31:0] vect_addr;
   logic any_vect;

   // true when a slot's enabled channel is requesting on the normal class
   function automatic logic slot_active(input logic [VIC_CTRL_CH_W:0] ctrl,
                                        input logic [VIC_NUM_CH-1:0] irq);
      logic hit;
      hit = 1'b0;
      if (ctrl[VIC_CTRL_EN_BIT] && (ctrl[VIC_CTRL_CH_W-1:0] < 5'(VIC_NUM_CH))) begin
         hit = irq[ctrl[VIC_CTRL_CH_W-1:0]];
      end
      return hit;
   endfunction : slot_active

   always_comb begin
      active_req = raw_req & enable;
      fast_status = active_req & fast_sel;
      irq_status = active_req & ~fast_sel;
      for (int s = 0; s < VIC_NUM_SLOTS; s++) begin
         slot_hit[s] = slot_active(slot_ctrl[s], irq_status);
      end
      vect_addr = default_addr;
      any_vect = 1'b0;
      // walk from the highest slot downward so slot 0 is written last and wins
      for (int s = VIC_NUM_SLOTS - 1; s >= 0; s--) begin
         if (slot_hit[s]) begin
            vect_addr = slot_addr[s];
            any_vect = 1'b1;
         end
      end
   end

   // ****************************************
   // core outputs
   // ****************************************
   // outputs follow the level; they fall once no enabled request of their class remains
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         fast_q <= 1'b0;
         normal_q <= 1'b0;
      end else begin
         fast_q <= |fast_status;
         normal_q <= |irq_status;
      end
   end
   assign fast_interrupt_request_out = fast_q;
   assign normal_interrupt_request_out = normal_q;

   // ****************************************
   // register bus
   // ****************************************
   logic wr_go;
   logic rd_go;
   logic [31:0] be_mask;
   logic [31:0] wdata;
   logic [3:0] slot_idx;
   logic rd_pending;
   logic wait_q;

   assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                     {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   assign wdata = avs_writedata_in & be_mask;
   // one wait cycle per access: read data is loaded on the first edge,
   // so it already stands when waitrequest is sampled low
   assign wr_go = avs_write_in && rd_pending;
   assign rd_go = avs_read_in && !rd_pending;
   assign slot_idx = avs_address_in[5:2];
   assign avs_waitrequest_out = wait_q;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rd_pending <= 1'b0;
      end else begin
         rd_pending <= (avs_read_in || avs_write_in) && !rd_pending;
      end
   end

   // waitrequest is the registered inverse of the acknowledge flop
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !((avs_read_in || avs_write_in) && !rd_pending);
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         fast_sel <= '0;
         enable <= '0;
         soft_req <= '0;
         default_addr <= VIC_ZERO;
         evt_mask <= '0;
      end else if (wr_go) begin
         unique case (avs_address_in)
            VIC_OFS_SELECT: fast_sel <= (fast_sel & ~be_mask[VIC_NUM_CH-1:0])
               | wdata[VIC_NUM_CH-1:0];
            VIC_OFS_ENABLE: enable <= enable | wdata[VIC_NUM_CH-1:0];
            VIC_OFS_ENABLE_CLR: enable <= enable & ~wdata[VIC_NUM_CH-1:0];
            VIC_OFS_SOFT_SET: soft_req <= soft_req | wdata[VIC_NUM_CH-1:0];
            VIC_OFS_SOFT_CLR: soft_req <= soft_req & ~wdata[VIC_NUM_CH-1:0];
            VIC_OFS_DEF_ADDR: default_addr <= (default_addr & ~be_mask) | wdata;
            VIC_OFS_EVT_MASK: evt_mask <= wdata[VIC_EVT_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         for (int s = 0; s < VIC_NUM_SLOTS; s++) begin
            slot_addr[s] <= VIC_ZERO;
            slot_ctrl[s] <= '0;
         end
      end else if (wr_go) begin
         if (avs_address_in >= VIC_OFS_SLOT_ADDR && avs_address_in < VIC_OFS_SLOT_CTRL) begin
            slot_addr[slot_idx] <= (slot_addr[slot_idx] & ~be_mask) | wdata;
         end else if (avs_address_in >= VIC_OFS_SLOT_CTRL
                      && avs_address_in < VIC_OFS_SLOT_END) begin
            slot_ctrl[slot_idx] <= wdata[VIC_CTRL_CH_W:0];
         end
      end
   end

   // ****************************************
   // sticky events and interrupt line
   // ****************************************
   logic [VIC_EVT_W-1:0] evt_set;
   logic [VIC_EVT_W-1:0] evt_clr;
   logic evt_irq;

   assign evt_set = {(|irq_status) & ~normal_q, (|fast_status) & ~fast_q};
   assign evt_clr = (wr_go && avs_address_in == VIC_OFS_EVT_STATUS)
                    ? wdata[VIC_EVT_W-1:0] : '0;

   // a rising request in the clearing cycle still sets the bit
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         evt_status <= '0;
         evt_irq <= 1'b0;
      end else begin
         evt_status <= (evt_status & ~evt_clr) | evt_set;
         evt_irq <= |(((evt_status & ~evt_clr) | evt_set) & evt_mask);
      end
   end
   assign event_interrupt_out = evt_irq;

   // ****************************************
   // read data
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         avs_readdata_out <= VIC_ZERO;
      end else if (rd_go) begin
         avs_readdata_out <= VIC_ZERO;
         if (avs_address_in >= VIC_OFS_SLOT_ADDR && avs_address_in < VIC_OFS_SLOT_CTRL) begin
            avs_readdata_out <= slot_addr[slot_idx];
         end else if (avs_address_in >= VIC_OFS_SLOT_CTRL
                      && avs_address_in < VIC_OFS_SLOT_END) begin
            avs_readdata_out <= {26'h000_0000, slot_ctrl[slot_idx]};
         end else begin
            unique case (avs_address_in)
               VIC_OFS_IRQ_STATUS: avs_readdata_out <= {4'h0, irq_status};
               VIC_OFS_FIQ_STATUS: avs_readdata_out <= {4'h0, fast_status};
               VIC_OFS_RAW: avs_readdata_out <= {4'h0, raw_req};
               VIC_OFS_SELECT: avs_readdata_out <= {4'h0, fast_sel};
               VIC_OFS_ENABLE: avs_readdata_out <= {4'h0, enable};
               VIC_OFS_SOFT_SET: avs_readdata_out <= {4'h0, soft_req};
               VIC_OFS_VECT_ADDR: avs_readdata_out <= vect_addr;
               VIC_OFS_DEF_ADDR: avs_readdata_out <= default_addr;
               VIC_OFS_EVT_STATUS: avs_readdata_out <= {30'h0000_0000, evt_status};
               VIC_OFS_EVT_MASK: avs_readdata_out <= {30'h0000_0000, evt_mask};
               default: avs_readdata_out <= VIC_ZERO;
            endcase
         end
      end
   end

   logic unused_any_vect;
   assign unused_any_vect = any_vect;

endmodule : vic_ctrl

// ### vic_ctrl_asserts.sv
// vic_ctrl_asserts: port-level checks of the interrupt controller
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module vic_ctrl_asserts
   import vic_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // register bus
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // core side
   input wire logic fast_interrupt_request_out,
   input wire logic normal_interrupt_request_out,
   input wire logic event_interrupt_out
);
   // ****************
   // bus and outputs
   // ****************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);
   sequence bus_req;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence bus_ack;
      !avs_waitrequest_out;
   endsequence
   ack_prompt_a: assert property (bus_req |=> bus_ack)
      else $error("access not answered after one wait cycle");
   wait_once_a: assert property (bus_ack |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   idle_wait_a: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out
      |=> avs_waitrequest_out)
      else $error("access answered without a request");
   unmapped_zero_a: assert property (avs_read_in && !avs_waitrequest_out
      && avs_address_in >= VIC_OFS_SLOT_END |=> avs_readdata_out == VIC_ZERO)
      else $error("unmapped read returned nonzero");
   rdata_hold_a: assert property (!(avs_read_in && avs_waitrequest_out)
      |=> $stable(avs_readdata_out))
      else $error("read data changed without a read");
   reset_quiet_a: assert property ($fell(reset_in) |-> !fast_interrupt_request_out
      && !normal_interrupt_request_out && !event_interrupt_out && avs_waitrequest_out)
      else $error("outputs active right after reset");
   event_cause_a: assert property ($rose(event_interrupt_out) |-> $past(avs_write_in, 2)
      || fast_interrupt_request_out || normal_interrupt_request_out)
      else $error("event interrupt rose without cause");
   event_sticky_a: assert property ($fell(event_interrupt_out) |-> $past(avs_write_in, 2))
      else $error("event interrupt dropped without a write");
endmodule : vic_ctrl_asserts

// ### vic_periph_model.sv
// vic_periph_model: peripherals, each channel request except channel 1 fanned to one of its flags
// assumes the bench picks channels; flags are level, active high, packed in port order
`timescale 1ns/100ps
module vic_periph_model
   import vic_pkg::*;
(
   // bench side
   input wire logic [VIC_NUM_CH-1:0] chan_req_in,
   input wire logic [2:0] pick_in,
   // peripheral flags
   output logic [60:0] flags_out
);
   // first flag and flag count of each channel; channel 1 has no hardware source
   localparam int BASE[28] = '{0, 0, 1, 2, 3, 11, 19, 23, 28, 35, 36, 38, 44, 45,
      47, 48, 49, 50, 51, 52, 53, 57, 54, 58, 55, 59, 56, 60};
   localparam int CNT[28] = '{1, 0, 1, 1, 8, 8, 4, 5, 7, 1, 2, 6, 1, 2,
      1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1};
   always_comb begin
      flags_out = '0;
      for (int ch = 0; ch < VIC_NUM_CH; ch++) begin
         if (chan_req_in[ch] && CNT[ch] > 0) begin
            flags_out[BASE[ch] + int'(pick_in) % CNT[ch]] = 1'b1;
         end
      end
   end
endmodule : vic_periph_model

// ### vic_ctrl_tb.sv
// vic_ctrl_tb: self-checking bench of the interrupt controller
// assumes the package, controller, peripheral model and checker are compiled first
`timescale 1ns/100ps
`define CHK(g, e) \
   begin \
      comparisons++; \
      if ((g) !== (e)) begin \
         n_mismatch++; \
         $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
      end \
   end
module vic_ctrl_tb
   import vic_pkg::*;
;
   logic clk_in = 0, reset_in = 1, avs_read_in = 0, avs_write_in = 0;
   logic [7:0] avs_address_in = 0;
   logic [31:0] avs_writedata_in = 0, avs_readdata_out, got;
   logic avs_waitrequest_out, fast_interrupt_request_out;
   logic normal_interrupt_request_out, event_interrupt_out;
   logic [27:0] req = 0;
   logic [2:0] pick = 0;
   logic [60:0] fl;
   int n_mismatch = 0, comparisons = 0, cycles = 0;
   int en = 0, sel = 0, def = 0;
   int sl_ch[16], sl_ad[16];
   logic [7:0] ofs[14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h30, 8'h34,
      8'h38, 8'h3C, 8'h40, 8'h80, 8'h20, 8'hC4};
   logic [27:0] pat[6] = '{28'h1, 28'h2010, 28'h10, 28'h200, 28'h4200, 28'h0};
   vic_periph_model vic_periph_model_inst (.chan_req_in(req), .pick_in(pick), .flags_out(fl));
   vic_ctrl vic_ctrl_inst (.clk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in,
      .avs_writedata_in, .avs_byteenable_in(4'hF), .avs_readdata_out, .avs_waitrequest_out,
      .watchdog_timeout_flag_in(fl[0]), .debug_comm_receive_in(fl[1]),
      .debug_comm_transmit_in(fl[2]), .timer0_flags_in(fl[10:3]), .timer1_flags_in(fl[18:11]),
      .uart0_rx_line_status_flag_in(fl[19]), .uart0_tx_holding_empty_flag_in(fl[20]),
      .uart0_rx_data_available_flag_in(fl[21]), .uart0_char_timeout_flag_in(fl[22]),
      .uart1_rx_line_status_flag_in(fl[23]), .uart1_tx_holding_empty_flag_in(fl[24]),
      .uart1_rx_data_available_flag_in(fl[25]), .uart1_char_timeout_flag_in(fl[26]),
      .uart1_modem_status_flag_in(fl[27]), .pwm_match_flags_in(fl[34:28]),
      .i2c_state_change_flag_in(fl[35]), .spi0_transfer_done_flag_in(fl[36]),
      .spi0_mode_fault_flag_in(fl[37]), .spi1_transfer_done_flag_in(fl[38]),
      .spi1_mode_fault_flag_in(fl[39]), .ssp_tx_fifo_flag_in(fl[40]),
      .ssp_rx_fifo_flag_in(fl[41]), .ssp_rx_timeout_flag_in(fl[42]),
      .ssp_rx_overrun_flag_in(fl[43]), .pll_locked_flag_in(fl[44]),
      .rtc_increment_flag_in(fl[45]), .rtc_alarm_flag_in(fl[46]),
      .ext_pin_request_in(fl[50:47]), .adc_done_flag_in(fl[51]), .can_filter_flag_in(fl[52]),
      .can_tx_flag_in(fl[56:53]), .can_rx_flag_in(fl[60:57]), .fast_interrupt_request_out,
      .normal_interrupt_request_out, .event_interrupt_out);
   always #25 clk_in = ~clk_in;
   // a full run needs under 3000 cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 6000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // ****************
   // bus master and model
   // ****************
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_write_in <= w;
      avs_read_in <= ~w;
      avs_writedata_in <= d;
      // hold the request until the edge at which waitrequest is sampled low
      do begin
         @(posedge clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      got = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask : bus
   task automatic settle();
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
   endtask : settle
   function automatic logic [31:0] m_vec();
      for (int s = 0; s < 16; s++) begin
         if (sl_ch[s] >= 0 && req[sl_ch[s]] && en[sl_ch[s]] && !sel[sl_ch[s]]) return sl_ad[s];
      end
      return def;
   endfunction : m_vec
   task automatic cfg();
      bus(1, VIC_OFS_SELECT, 32'(sel));
      bus(1, VIC_OFS_ENABLE_CLR, 32'hFFFF_FFFF);
      bus(1, VIC_OFS_ENABLE, 32'(en));
      bus(1, VIC_OFS_DEF_ADDR, 32'(def));
      for (int s = 0; s < VIC_NUM_SLOTS; s++) begin
         bus(1, VIC_OFS_SLOT_ADDR + 8'(4 * s), 32'(sl_ad[s]));
         bus(1, VIC_OFS_SLOT_CTRL + 8'(4 * s), (sl_ch[s] < 0) ? VIC_ZERO : 32'(sl_ch[s] + 32));
      end
   endtask : cfg
   task automatic chk_all();
      int fm, nm;
      settle();
      fm = req & en & sel;
      nm = req & en & ~sel;
      `CHK(fast_interrupt_request_out, fm != 0)
      `CHK(normal_interrupt_request_out, nm != 0)
      bus(0, VIC_OFS_FIQ_STATUS, 0);
      `CHK(got, 32'(fm))
      bus(0, VIC_OFS_IRQ_STATUS, 0);
      `CHK(got, 32'(nm))
      bus(0, VIC_OFS_VECT_ADDR, 0);
      `CHK(got, m_vec())
   endtask : chk_all
   task automatic tally_and_finish();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   // ****************
   // scenarios
   // ****************
   initial begin
      void'($urandom(32'h1af1));
      for (int s = 0; s < 16; s++) begin
         sl_ch[s] = -1;
         sl_ad[s] = 0;
      end
      repeat (4) @(posedge clk_in);
      reset_in <= 1'b0;
      // writes to a hole and to a read-only place must leave no trace
      bus(1, 8'h20, 32'hFFFF_FFFF);
      bus(1, VIC_OFS_RAW, 32'hFFFF_FFFF);
      foreach (ofs[i]) begin
         bus(0, ofs[i], 0);
         `CHK(got, VIC_ZERO)
      end
      for (int ch = 0; ch < VIC_NUM_CH; ch++) begin
         req <= (ch == VIC_CH_SOFT) ? 28'h0 : 28'h1 << ch;
         pick <= 3'($urandom);
         if (ch == VIC_CH_SOFT) bus(1, VIC_OFS_SOFT_SET, 32'h0000_0002);
         settle();
         bus(0, VIC_OFS_RAW, 0);
         `CHK(got, 32'h0000_0001 << ch)
         if (ch == VIC_CH_SOFT) bus(1, VIC_OFS_SOFT_CLR, 32'h0000_0002);
      end
      bus(1, VIC_OFS_EVT_MASK, 32'h0000_0003);
      sel = 32'h0000_4001;
      en = 32'h0000_6211;
      def = 32'h0000_0F00;
      sl_ch[1] = 13;
      sl_ad[1] = 32'h0000_0100;
      sl_ch[3] = 4;
      sl_ad[3] = 32'h0000_0300;
      for (int p = 0; p < 2; p++) begin
         if (p == 1) begin
            sel = sel | 16;
            sl_ch[0] = 9;
            sl_ad[0] = 32'h0000_00A0;
         end
         cfg();
         for (int i = 0; i < 8; i++) begin
            @(posedge clk_in);
            req <= (i < 6) ? pat[i] : 28'($urandom) & 28'hFFF_FFFD;
            chk_all();
         end
      end
      bus(0, VIC_OFS_EVT_STATUS, 0);
      `CHK(got, 32'h0000_0003)
      `CHK(event_interrupt_out, 1'b1)
      bus(1, VIC_OFS_EVT_STATUS, 32'h0000_0003);
      bus(1, VIC_OFS_EVT_MASK, VIC_ZERO);
      @(posedge clk_in);
      req <= 28'h0;
      settle();
      @(posedge clk_in);
      req <= 28'h1;
      settle();
      bus(0, VIC_OFS_EVT_STATUS, 0);
      `CHK(got, 32'h0000_0001)
      `CHK(event_interrupt_out, 1'b0)
      bus(1, VIC_OFS_EVT_MASK, 32'h0000_0001);
      settle();
      `CHK(event_interrupt_out, 1'b1)
      bus(1, VIC_OFS_EVT_STATUS, 32'h0000_0001);
      settle();
      `CHK(event_interrupt_out, 1'b0)
      tally_and_finish();
   end
endmodule : vic_ctrl_tb
bind vic_ctrl vic_ctrl_asserts vic_ctrl_asserts_inst (.clk_in, .reset_in, .avs_address_in,
   .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out,
   .fast_interrupt_request_out, .normal_interrupt_request_out, .event_interrupt_out);
